// >>> src/cpf_defs.svh
// Purpose: Timing counts and field positions for card power fault control
// Assumes: 50 MHz clock
// Notes:   Command byte and fault status bit positions
`ifndef CPF_DEFS_SVH
`define CPF_DEFS_SVH
`define CPF_CLK_MHZ        50
`define CPF_OC_PERSIST_NS  2000
`define CPF_OC_CYCLES      ((`CPF_OC_PERSIST_NS * `CPF_CLK_MHZ) / 1000)
`define CPF_RETRY_OFF_NS   1000
`define CPF_RETRY_CYCLES   ((`CPF_RETRY_OFF_NS * `CPF_CLK_MHZ) / 1000)
`define CPF_CNT_W          8
`define CPF_CMD_SEL_BIT    7
`define CPF_CMD_MAIN_ON    6
`define CPF_CMD_RAIL_LOW   5
`define CPF_CMD_MAIN_FLT   4
`define CPF_CMD_PROG_ON    3
`define CPF_CMD_PROG_SRC   2
`define CPF_CMD_PROG_FLT   1
`define CPF_ST_CAT         7
`define CPF_ST_AM          6
`define CPF_ST_AP          5
`define CPF_ST_BM          4
`define CPF_ST_BP          3
`define CPF_CMD_RESET      8'h00
`endif

// >>> src/cpf_pkg.sv
// Purpose: Types for card power fault control
// Assumes: Constants come from cpf_defs.svh
// Notes:   Switch state per output
package cpf_pkg;
    typedef enum logic [1:0] {
        CPF_OUT_FLOAT,
        CPF_OUT_GND,
        CPF_OUT_HIGH_RAIL,
        CPF_OUT_LOW_RAIL
    } cpf_main_t;
    typedef enum logic [1:0] {
        CPF_PP_FLOAT,
        CPF_PP_GND,
        CPF_PP_PROG_RAIL,
        CPF_PP_MAIN
    } cpf_prog_t;
    typedef struct packed {
        cpf_main_t main_sel;
        cpf_prog_t prog_sel;
    } cpf_chan_t;
endpackage : cpf_pkg

// >>> src/cpf_power_ctrl.sv
// Purpose: Card power switch control with fault protection and alert
// Assumes: Comparator flags are asynchronous; command bytes come from
//          a serial engine on the same clock as one-cycle strobes
// Notes:   Alert line is open drain; only its enable is driven
`include "cpf_defs.svh"
// Overview of operation
// R1 - Suspend pin low selects suspend commands
// R2 - Alert low on limit, lockout or thermal
// R3 - Overcurrent: brief off, then controlled restart
// R4 - Alert latches only after 2 us overcurrent
// R5 - Short circuit keeps pulsing until thermal
// R6 - Thermal opens every switch, alerts
// R7 - Thermal clear restores commanded switches
// R8 - Thermal and overcurrent alternate, no lockout
// R9 - Main rail below 1.5 V: off, alert
// R10 - Absent selected rail floats output, alerts
// R11 - Prog switch waits for 8 V first
// R12 - Prog switch works until 2 V, floats
// R13 - Logic rail low: everything floats
// R14 - Normal, standby and shutdown modes; the code outputs only normal_mode, set while any switch conducts
// R15 - Host enters shutdown by lowering logic rail
// R16 - Alert only pulled low or released
// R17 - Bits 6..4: main on, rail, float
// R18 - Bits 3..1: prog on, source, float
// R19 - Bit 7 routes byte; reset zero
// R20 - Latched status: catastrophic and four faults
// R21 - Synchronise comparators, count persistence in cycles
module cpf_power_ctrl (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Command writes from serial engine
    input  wire logic             cmd_wr_a,
    input  wire logic             cmd_wr_b,
    input  wire logic [7:0]       cmd_byte,
    input  wire logic             status_rd,
    // Suspend pin
    input  wire logic             suspend_b,
    // Analog comparators (asynchronous)
    input  wire logic             logic_rail_ok,
    input  wire logic             high_main_rail_ok,
    input  wire logic             low_main_rail_ok,
    input  wire logic [1:0]       prog_rail_above_8v,
    input  wire logic [1:0]       prog_rail_above_2v,
    input  wire logic [3:0]       oc_flags,
    input  wire logic             thermal_hot,
    // Switch controls
    output cpf_pkg::cpf_chan_t    socket_a_ctrl,
    output cpf_pkg::cpf_chan_t    socket_b_ctrl,
    output logic                  normal_mode,
    // Status and alert
    output logic [7:0]            fault_status,
    output logic                  alert_oe
);
    localparam int NSYNC = 12;
    // Reset image: rails good, faults clear, prog rails unarmed,
    // so no false catastrophic flag follows reset release
    localparam logic [NSYNC-1:0] SYNC_IDLE = 12'h007;
    logic [NSYNC-1:0] s1_q, s2_q, raw;
    assign raw = {thermal_hot, oc_flags, prog_rail_above_2v,
                  prog_rail_above_8v, low_main_rail_ok,
                  high_main_rail_ok, logic_rail_ok};

    // Two-stage synchronisers on all comparators
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q[gi] <= SYNC_IDLE[gi];
                    s2_q[gi] <= SYNC_IDLE[gi];
                end else begin
                    s1_q[gi] <= raw[gi];                 // [R21]
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic       vl_ok, hi_ok, lo_ok, hot;
    logic [1:0] pp8, pp2;
    logic [3:0] oc;
    assign vl_ok = s2_q[0];
    assign hi_ok = s2_q[1];
    assign lo_ok = s2_q[2];
    assign pp8   = s2_q[4:3];
    assign pp2   = s2_q[6:5];
    assign oc    = s2_q[10:7];
    assign hot   = s2_q[11];

    // Overcurrent guards, order: A main, A prog, B main, B prog
    logic [3:0] sw_off, oc_long;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_guard
            cpf_sw_guard u_guard (
                .clock   (clock),
                .rst_b   (rst_b),
                .oc_in   (oc[gi]),
                .sw_off  (sw_off[gi]),
                .oc_long (oc_long[gi])
            );
        end
    endgenerate

    // Command store: [0]=A, [1]=B; normal and suspend banks
    logic [6:0] norm_q [2], norm_d [2];
    logic [6:0] susp_q [2], susp_d [2];
    logic [1:0] pp_en_q, pp_en_d;
    logic [7:0] stat_q, stat_d;
    cpf_pkg::cpf_chan_t ch_q [2], ch_d [2];
    logic       alert_q, alert_d, norm_mode_q, norm_mode_d;
    logic [6:0] cmd;
    logic       rail_ok, rail_bad, on_any;
    logic [1:0] main_fault, prog_fault;
    logic       cat;

    always_comb begin
        norm_d  = norm_q;
        susp_d  = susp_q;
        pp_en_d = pp_en_q;
        stat_d  = stat_q;
        on_any  = 1'b0;
        cat     = hot || !vl_ok;
        // Bit 7 picks which bank the byte lands in
        for (int c = 0; c < 2; c++) begin
            if ((c == 0 && cmd_wr_a) || (c == 1 && cmd_wr_b)) begin
                if (cmd_byte[`CPF_CMD_SEL_BIT])
                    norm_d[c] = cmd_byte[6:0];            // [R19]
                else
                    susp_d[c] = cmd_byte[6:0];            // [R19]
            end
        end
        for (int c = 0; c < 2; c++) begin
            // Prog switch armed at 8 V, disarmed below 2 V
            if (!pp2[c])
                pp_en_d[c] = 1'b0;                        // [R12]
            else if (pp8[c])
                pp_en_d[c] = 1'b1;                        // [R11]
            cmd = suspend_b ? norm_q[c] : susp_q[c];      // [R1]
            rail_ok  = cmd[`CPF_CMD_RAIL_LOW] ? lo_ok : hi_ok;
            rail_bad = 1'b0;
            prog_fault[c] = 1'b0;
            // Main output: float overrides on, else gnd
            if (cmd[`CPF_CMD_MAIN_FLT])
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_FLOAT; // [R17]
            else if (!cmd[`CPF_CMD_MAIN_ON])
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_GND;   // [R17]
            else if (!rail_ok) begin
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_FLOAT; // [R9] [R10]
                rail_bad = 1'b1;
            end else if (sw_off[2*c])
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_FLOAT; // [R3]
            else if (cmd[`CPF_CMD_RAIL_LOW])
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_LOW_RAIL;
            else
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_HIGH_RAIL;
            main_fault[c] = rail_bad || oc_long[2*c];
            // Prog output
            if (cmd[`CPF_CMD_PROG_FLT])
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_FLOAT;  // [R18]
            else if (!cmd[`CPF_CMD_PROG_ON])
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_GND;    // [R18]
            else if (cmd[`CPF_CMD_PROG_SRC] && !pp_en_q[c]) begin
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_FLOAT;  // [R11] [R12]
                prog_fault[c] = 1'b1;
            end else if (sw_off[2*c+1])
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_FLOAT;  // [R3] [R5]
            else if (cmd[`CPF_CMD_PROG_SRC])
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_PROG_RAIL;
            else
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_MAIN;
            prog_fault[c] = prog_fault[c] || oc_long[2*c+1];
            // Thermal or logic lockout opens everything, ground too
            if (cat) begin // No lockout: released when cat clears [R7] [R8]
                ch_d[c].main_sel = cpf_pkg::CPF_OUT_FLOAT; // [R6] [R13]
                ch_d[c].prog_sel = cpf_pkg::CPF_PP_FLOAT;  // [R6] [R13]
            end
            if (ch_d[c].main_sel inside {cpf_pkg::CPF_OUT_HIGH_RAIL,
                                         cpf_pkg::CPF_OUT_LOW_RAIL} ||
                ch_d[c].prog_sel inside {cpf_pkg::CPF_PP_PROG_RAIL,
                                         cpf_pkg::CPF_PP_MAIN})
                on_any = 1'b1;
        end
        // Status: set wins over read-clear
        if (status_rd)
            stat_d = 8'h00;
        stat_d[`CPF_ST_CAT] = stat_d[`CPF_ST_CAT] | cat;   // [R20]
        stat_d[`CPF_ST_AM]  = stat_d[`CPF_ST_AM] | main_fault[0];
        stat_d[`CPF_ST_AP]  = stat_d[`CPF_ST_AP] | prog_fault[0];
        stat_d[`CPF_ST_BM]  = stat_d[`CPF_ST_BM] | main_fault[1];
        stat_d[`CPF_ST_BP]  = stat_d[`CPF_ST_BP] | prog_fault[1];
        // Alert follows latched status, held until a status read clears it
        alert_d = (stat_d[7:3] != 5'h00);                 // [R2] [R4]
        norm_mode_d = on_any;                             // [R14]
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < 2; c++) begin
                norm_q[c] <= 7'(`CPF_CMD_RESET);
                susp_q[c] <= 7'(`CPF_CMD_RESET);
                ch_q[c]   <= '{cpf_pkg::CPF_OUT_FLOAT,
                               cpf_pkg::CPF_PP_FLOAT};
            end
            pp_en_q     <= 2'b00;
            stat_q      <= 8'h00;
            alert_q     <= 1'b0;
            norm_mode_q <= 1'b0;
        end else begin
            norm_q      <= norm_d;
            susp_q      <= susp_d;
            ch_q        <= ch_d;
            pp_en_q     <= pp_en_d;
            stat_q      <= stat_d;
            alert_q     <= alert_d;
            norm_mode_q <= norm_mode_d;
        end
    end

    assign socket_a_ctrl = ch_q[0];
    assign socket_b_ctrl = ch_q[1];
    assign fault_status  = stat_q;
    assign normal_mode   = norm_mode_q;
    assign alert_oe      = alert_q;   // Drives low only [R16]

    property p_cat_floats;
        @(posedge clock) disable iff (!rst_b)
        (hot || !vl_ok) |=> {socket_a_ctrl, socket_b_ctrl} == 8'h00;
    endproperty
    a_cat_floats: assert property (p_cat_floats) // [R6]
        else $error("Switches not opened on catastrophic fault");

    property p_cat_alert;
        @(posedge clock) disable iff (!rst_b)
        hot |=> alert_oe && fault_status[7];
    endproperty
    a_cat_alert: assert property (p_cat_alert) // [R2]
        else $error("Alert not raised on thermal fault");

    property p_pp_disarm;
        @(posedge clock) disable iff (!rst_b)
        !pp2[0] |=> ##1 socket_a_ctrl.prog_sel != cpf_pkg::CPF_PP_PROG_RAIL;
    endproperty
    a_pp_disarm: assert property (p_pp_disarm) // [R12]
        else $error("Prog switch still on below 2 V");

    property p_rail_absent;
        @(posedge clock) disable iff (!rst_b)
        !hi_ok |=> socket_a_ctrl.main_sel != cpf_pkg::CPF_OUT_HIGH_RAIL;
    endproperty
    a_rail_absent: assert property (p_rail_absent) // [R10]
        else $error("Absent rail connected");

    property p_recover;
        @(posedge clock) disable iff (!rst_b)
        ($fell(hot) && vl_ok && hi_ok && !sw_off[0] && suspend_b &&
         norm_q[0][6:4] == 3'b100 && !cmd_wr_a)
        |=> socket_a_ctrl.main_sel == cpf_pkg::CPF_OUT_HIGH_RAIL;
    endproperty
    a_recover: assert property (p_recover) // [R7]
        else $error("Switch not restored after thermal");

    property p_status_sticky;
        @(posedge clock) disable iff (!rst_b)
        (fault_status[6] && !status_rd) |=> fault_status[6];
    endproperty
    a_status_sticky: assert property (p_status_sticky) // [R20]
        else $error("Fault status lost without read");

    property p_route;
        @(posedge clock) disable iff (!rst_b)
        (cmd_wr_b && !cmd_byte[7]) |=> susp_q[1] == $past(cmd_byte[6:0]);
    endproperty
    a_route: assert property (p_route) // [R19]
        else $error("Suspend byte misrouted");
endmodule : cpf_power_ctrl

// >>> src/cpf_sw_guard.sv
// Purpose: Per-switch overcurrent retry and persistence timer
// Assumes: oc_in already synchronised to clock
// Notes:   Off pulse then controlled restart; long events flagged while oc_in stays high
`include "cpf_defs.svh"
module cpf_sw_guard (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Fault input
    input  wire logic oc_in,
    // Results
    output logic      sw_off,
    output logic      oc_long
);
    logic [`CPF_CNT_W-1:0] pers_q, pers_d;
    logic [`CPF_CNT_W-1:0] off_q, off_d;
    logic                  long_q, long_d;

    always_comb begin
        pers_d = oc_in ? pers_q : '0;
        long_d = 1'b0;
        if (oc_in && pers_q != `CPF_CNT_W'(`CPF_OC_CYCLES))
            pers_d = pers_q + 1'b1;
        if (oc_in && pers_q == `CPF_CNT_W'(`CPF_OC_CYCLES))
            long_d = 1'b1;                           // [R4]
        // Each limit event forces a short off time, repeating on a short
        if (oc_in && off_q == '0)
            off_d = `CPF_CNT_W'(`CPF_RETRY_CYCLES);  // [R3] [R5]
        else if (off_q != '0)
            off_d = off_q - 1'b1;
        else
            off_d = '0;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pers_q <= '0;
            off_q  <= '0;
            long_q <= 1'b0;
        end else begin
            pers_q <= pers_d;
            off_q  <= off_d;
            long_q <= long_d;
        end
    end

    assign sw_off  = off_q != '0;
    assign oc_long = long_q;

    property p_long_needs_persist;
        @(posedge clock) disable iff (!rst_b)
        $rose(long_q) |-> $past(oc_in, 2) && $past(oc_in, 1);
    endproperty
    a_long_needs_persist: assert property (p_long_needs_persist) // [R4]
        else $error("Overcurrent latched without persistence");

    property p_off_on_event;
        @(posedge clock) disable iff (!rst_b)
        (oc_in && off_q == '0) |=> sw_off [*2];
    endproperty
    a_off_on_event: assert property (p_off_on_event) // [R3]
        else $error("Switch not turned off on overcurrent");
endmodule : cpf_sw_guard

// >>> test/cpf_host_model.sv
// Purpose: Host side of the card power block: command writes, status reads
// Assumes: Strobes change 1 ns after the rising edge, one cycle wide
// Notes:   Holds the alert pull-up; the block only pulls the line low
module cpf_host_model (
    // Clock
    input  wire logic       clock,
    // Command and status access
    output logic            cmd_wr_a,
    output logic            cmd_wr_b,
    output logic [7:0]      cmd_byte,
    output logic            status_rd,
    input  wire logic [7:0] fault_status,
    // Alert line
    input  wire logic       alert_oe,
    output logic            alert_line
);
    timeunit 1ns;
    timeprecision 100ps;

    assign alert_line = alert_oe ? 1'b0 : 1'b1;

    initial begin
        cmd_wr_a  = 1'b0;
        cmd_wr_b  = 1'b0;
        cmd_byte  = 8'h00;
        status_rd = 1'b0;
    end

    // One command byte to channel A (chan 0) or B (chan 1)
    task automatic write_cmd(input logic chan, input logic [7:0] b);
        @(posedge clock);
        #1;
        cmd_byte = b;
        cmd_wr_a = ~chan;
        cmd_wr_b = chan;
        @(posedge clock);
        #1;
        cmd_wr_a = 1'b0;
        cmd_wr_b = 1'b0;
        cmd_byte = ~b;
    endtask : write_cmd

    // Status is taken while it stands, before the strobe's edge clears it
    task automatic read_status(output logic [7:0] v);
        @(posedge clock);
        #1;
        status_rd = 1'b1;
        v = fault_status;
        @(posedge clock);
        #1;
        status_rd = 1'b0;
    endtask : read_status
endmodule : cpf_host_model

// >>> test/test_cpf_power_ctrl.sv
// Purpose: Self-checking bench for card power switch control
// Assumes: Comparator inputs reach outputs within 4 edges
// Notes:   Host accesses go through the host model tasks
module test_cpf_power_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic               clock = 1'b0;
    logic               rst_b = 1'b0;
    logic               suspend_b = 1'b1;
    logic               logic_rail_ok = 1'b1;
    logic               high_main_rail_ok = 1'b1;
    logic               low_main_rail_ok = 1'b1;
    logic [1:0]         prog_rail_above_8v = 2'h3;
    logic [1:0]         prog_rail_above_2v = 2'h3;
    logic [3:0]         oc_flags = 4'h0;
    logic               thermal_hot = 1'b0;
    logic               cmd_wr_a, cmd_wr_b, status_rd, normal_mode;
    logic               alert_oe, alert_line;
    logic [7:0]         cmd_byte, fault_status, st;
    cpf_pkg::cpf_chan_t socket_a_ctrl, socket_b_ctrl;
    int                 error_cnt = 0;
    int                 n_tests = 0;
    int                 cyc = 0;
    int                 n_on, n_off;
    logic [7:0]         tbl [8] = '{8'hc0, 8'he0, 8'hd0, 8'h8c,
                                    8'h88, 8'h8a, 8'hce, 8'h80};

    always #10 clock = ~clock;

    cpf_power_ctrl u_cpf_power_ctrl (
        .clock(clock), .rst_b(rst_b), .cmd_wr_a(cmd_wr_a),
        .cmd_wr_b(cmd_wr_b), .cmd_byte(cmd_byte), .status_rd(status_rd),
        .suspend_b(suspend_b), .logic_rail_ok(logic_rail_ok),
        .high_main_rail_ok(high_main_rail_ok),
        .low_main_rail_ok(low_main_rail_ok),
        .prog_rail_above_8v(prog_rail_above_8v),
        .prog_rail_above_2v(prog_rail_above_2v), .oc_flags(oc_flags),
        .thermal_hot(thermal_hot), .socket_a_ctrl(socket_a_ctrl),
        .socket_b_ctrl(socket_b_ctrl), .normal_mode(normal_mode),
        .fault_status(fault_status), .alert_oe(alert_oe));

    cpf_host_model u_cpf_host_model (
        .clock(clock), .cmd_wr_a(cmd_wr_a), .cmd_wr_b(cmd_wr_b),
        .cmd_byte(cmd_byte), .status_rd(status_rd),
        .fault_status(fault_status), .alert_oe(alert_oe),
        .alert_line(alert_line));

    // Switch state that a command byte asks for
    function automatic logic [3:0] exp_ctrl(input logic [7:0] b);
        cpf_pkg::cpf_main_t m;
        cpf_pkg::cpf_prog_t p;
        m = b[4] ? cpf_pkg::CPF_OUT_FLOAT : !b[6] ? cpf_pkg::CPF_OUT_GND :
            b[5] ? cpf_pkg::CPF_OUT_LOW_RAIL : cpf_pkg::CPF_OUT_HIGH_RAIL;
        p = b[1] ? cpf_pkg::CPF_PP_FLOAT : !b[3] ? cpf_pkg::CPF_PP_GND :
            b[2] ? cpf_pkg::CPF_PP_PROG_RAIL : cpf_pkg::CPF_PP_MAIN;
        return {m, p};
    endfunction : exp_ctrl

    function automatic logic conducts(input logic [3:0] c);
        return c[3] | c[1];
    endfunction : conducts

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            $display("BAD %0t run did not finish", $time);
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        #1;
        check({socket_a_ctrl, socket_b_ctrl, alert_oe}, 8'h00, "reset");
        check(fault_status, 8'h00, "reset status");
        rst_b = 1'b1;
        settle(4);
        // Decode table, A and B written back to back
        for (int i = 0; i < 8; i++) begin
            u_cpf_host_model.write_cmd(1'b0, tbl[i]);
            u_cpf_host_model.write_cmd(1'b1, tbl[(i + 3) % 8]);
            settle(1);
            check(socket_a_ctrl, exp_ctrl(tbl[i]), "decode a");
            check(socket_b_ctrl, exp_ctrl(tbl[(i + 3) % 8]), "decode b");
            check(normal_mode, conducts(exp_ctrl(tbl[i])) |
                  conducts(exp_ctrl(tbl[(i + 3) % 8])), "mode");
        end
        // Suspend bank takes over only while suspend_b is low
        u_cpf_host_model.write_cmd(1'b0, 8'hc0);
        u_cpf_host_model.write_cmd(1'b0, 8'h48);
        u_cpf_host_model.write_cmd(1'b1, 8'h08);
        settle(1);
        check(socket_a_ctrl, exp_ctrl(8'hc0), "normal bank");
        suspend_b = 1'b0;
        settle(2);
        check(socket_a_ctrl, exp_ctrl(8'h48), "suspend bank");
        check(socket_b_ctrl, exp_ctrl(8'h08), "suspend bank b");
        suspend_b = 1'b1;
        settle(2);
        check(socket_a_ctrl, exp_ctrl(8'hc0), "back to normal");
        // Absent rail selected, then present rail
        high_main_rail_ok = 1'b0;
        settle(5);
        check(socket_a_ctrl, {2'h0, exp_ctrl(8'hc0) & 4'h3}, "absent");
        check(fault_status[6], 1'b1, "absent flag");
        check(alert_line, 1'b0, "absent alert");
        u_cpf_host_model.write_cmd(1'b0, 8'he0);
        settle(1);
        check(socket_a_ctrl, exp_ctrl(8'he0), "present rail");
        high_main_rail_ok = 1'b1;
        settle(5);
        u_cpf_host_model.read_status(st);
        u_cpf_host_model.read_status(st);
        check(st, 8'h00, "cleared");
        settle(2);
        check(alert_line, 1'b1, "released");
        low_main_rail_ok = 1'b0;
        settle(5);
        check(socket_a_ctrl, exp_ctrl(8'he0) & 4'h3, "low rail uv");
        check(fault_status[6], 1'b1, "uv flag");
        low_main_rail_ok = 1'b1;
        u_cpf_host_model.write_cmd(1'b0, 8'hc0);
        settle(5);
        u_cpf_host_model.read_status(st);
        // Short overcurrent: switch off, no latch
        oc_flags[0] = 1'b1;
        settle(5);
        check(socket_a_ctrl.main_sel, cpf_pkg::CPF_OUT_FLOAT, "oc off");
        settle(35);
        oc_flags[0] = 1'b0;
        settle(70);
        check(socket_a_ctrl, exp_ctrl(8'hc0), "oc restart");
        check(fault_status, 8'h00, "short oc");
        check(alert_line, 1'b1, "short oc alert");
        // Lasting short: pulsing and latched alert
        n_on = 0;
        n_off = 0;
        oc_flags[0] = 1'b1;
        settle(5);
        repeat (300) begin
            settle(1);
            if (socket_a_ctrl.main_sel === cpf_pkg::CPF_OUT_FLOAT)
                n_off++;
            else
                n_on++;
        end
        check(n_on > 0 && n_off > 0, 1'b1, "pulsing");
        check(fault_status[6], 1'b1, "long oc flag");
        check(alert_line, 1'b0, "long oc alert");
        // Thermal while the short persists, then recovery
        u_cpf_host_model.write_cmd(1'b1, 8'h80);
        thermal_hot = 1'b1;
        settle(5);
        check({socket_a_ctrl, socket_b_ctrl}, 8'h00, "hot");
        check(fault_status[7], 1'b1, "hot flag");
        check(alert_line, 1'b0, "hot alert");
        thermal_hot = 1'b0;
        settle(5);
        check(socket_b_ctrl, exp_ctrl(8'h80), "cool");
        check(socket_a_ctrl.prog_sel, cpf_pkg::CPF_PP_GND, "cool a");
        oc_flags[0] = 1'b0;
        settle(120);
        u_cpf_host_model.read_status(st);
        check(socket_a_ctrl, exp_ctrl(8'hc0), "recovered");
        // Thermal pulse with no short: plain restart
        thermal_hot = 1'b1;
        settle(5);
        check(socket_a_ctrl, 8'h00, "hot again");
        thermal_hot = 1'b0;
        settle(5);
        check(socket_a_ctrl, exp_ctrl(8'hc0), "cool again");
        // Programming supply arming and disarming
        u_cpf_host_model.write_cmd(1'b0, 8'hcc);
        prog_rail_above_8v[0] = 1'b0;
        prog_rail_above_2v[0] = 1'b0;
        settle(5);
        check(socket_a_ctrl.prog_sel, cpf_pkg::CPF_PP_FLOAT, "prog gone");
        prog_rail_above_2v[0] = 1'b1;
        settle(5);
        check(socket_a_ctrl.prog_sel, cpf_pkg::CPF_PP_FLOAT, "not armed");
        prog_rail_above_8v[0] = 1'b1;
        settle(5);
        check(socket_a_ctrl.prog_sel, cpf_pkg::CPF_PP_PROG_RAIL, "armed");
        prog_rail_above_8v[0] = 1'b0;
        settle(5);
        check(socket_a_ctrl.prog_sel, cpf_pkg::CPF_PP_PROG_RAIL, "held");
        // Logic rail low floats everything
        logic_rail_ok = 1'b0;
        settle(5);
        check({socket_a_ctrl, socket_b_ctrl}, 8'h00, "shutdown");
        check(normal_mode, 1'b0, "shutdown mode");
        test_done();
    end
endmodule : test_cpf_power_ctrl
